/* File: rtl/fuse_config_decode.v */
// configuration byte decoder with AXI4-Lite read-back
//
// Behaviour
// - frequency code 1 runs oscillator at 16 MHz, 2 at 20 MHz, with matching trim
// - timer fault byte copied bit for bit into timer fault control
// - upper four timer bits enable compare outputs onto pins
// - lower four bits set compare default levels, also on debug entry with fault detect flag set
// - scan source picks full flash, boot, boot plus code, or none
// - reset-pin function: 0 gpio, 1 debug interface, 2 reset input
// - gpio-mode reset pin driver held off 768 slow cycles after reset
// - chip erase keeps eeprom when keep bit is 1, erases when 0
// - locked device always erases eeprom on chip erase
// - start-up delay codes 0..7 select 0,1,2,4,8,16,32,64 ms
// - application end in 256-byte blocks, rest of flash is data
// - zero application end makes flash from boot end onward code
// - boot end in 256-byte blocks, zero makes whole flash boot
// - both ends zero make whole flash boot
// - only key 0xC5 unlocks memory access, else locked
// - locked blocks debug interface from system bus except info block
`timescale 1ns/1ps
`include "fuse_cfg_consts.vh"

module fuse_config_decode #(
  parameter HOLDOFF_CLKS = `HOLDOFF_CLKS,
  parameter CLKS_PER_MS  = `CLKS_PER_MS
) (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire [7:0]  nv_osc_cfg_i,
  input  wire [7:0]  nv_timer_fault_i,
  input  wire [7:0]  nv_sys_primary_i,
  input  wire [7:0]  nv_startup_i,
  input  wire [7:0]  nv_app_end_i,
  input  wire [7:0]  nv_boot_end_i,
  input  wire [7:0]  nv_lock_key_i,
  input  wire [1:0]  osc_trim_16m_i,
  input  wire [7:0]  osc_coarse_16m_i,
  input  wire [7:0]  osc_coarse_20m_i,
  input  wire [3:0]  osc_temp_16m_i,
  input  wire [3:0]  osc_temp_20m_i,
  input  wire        debug_entry_i,
  input  wire        fault_detect_flag_i,
  input  wire        dbg_req_i,
  input  wire        dbg_is_info_blk_i,
  input  wire [7:0]  flash_blk_i,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [31:0] s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         osc_run_20m_o,
  output reg         osc_cfg_valid_o,
  output reg  [7:0]  osc_coarse_trim_o,
  output reg  [3:0]  osc_temp_trim_o,
  output reg  [7:0]  timer_fault_control_o,
  output reg  [3:0]  cmp_pin_out_en_o,
  output reg  [3:0]  cmp_level_o,
  output reg  [1:0]  scan_source_sel_o,
  output reg  [1:0]  shared_reset_pin_func_o,
  output reg         gpio_drv_allow_o,
  output reg         eeprom_erase_o,
  output reg         start_exec_o,
  output reg         locked_o,
  output reg         dbg_grant_o,
  output reg  [1:0]  flash_region_o
);

  // ========================================================================
  // state
  localparam ST_LOAD = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN  = 2'h2;

  localparam [1:0] REG_BOOT = 2'h0;
  localparam [1:0] REG_CODE = 2'h1;
  localparam [1:0] REG_DATA = 2'h2;

  reg [1:0]  state_reg;
  reg [7:0]  osc_reg;
  reg [7:0]  tfault_reg;
  reg [7:0]  sys0_reg;
  reg [7:0]  sut_reg;
  reg [7:0]  app_code_end_cfg_reg;
  reg [7:0]  boot_section_end_reg;
  reg [7:0]  lock_reg;
  reg [23:0] hold_cnt_reg;
  reg [31:0] sut_cnt_reg;
  reg        erase_req_reg;
  reg        aw_got_reg;
  reg        w_got_reg;
  reg [3:0]  aw_idx_reg;
  reg [7:0]  wdata_reg;
  reg [31:0] rdata_next;
  reg [1:0]  region_next;
  reg [31:0] sut_target;

  // start-up delay in ms: 0, then powers of two
  function [31:0] sut_ms;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        sut_ms = 32'h0;
      end else begin
        sut_ms = 32'h1 << (code - 3'h1);
      end
    end
  endfunction

  // oscillator code decode
  function freq_is_20m;
    input [1:0] code;
    begin
      freq_is_20m = (code == `FREQ_20M);
    end
  endfunction

  function freq_is_valid;
    input [1:0] code;
    begin
      freq_is_valid = (code == `FREQ_16M) || (code == `FREQ_20M);
    end
  endfunction

  // shared reset pin function field
  function [1:0] pin_func_of;
    input [7:0] sys;
    begin
      pin_func_of = sys[`RST_FUNC_LSB+1:`RST_FUNC_LSB];
    end
  endfunction

  wire [3:0] ar_idx = s_axi_araddr[5:2];
  wire       unlocked = (lock_reg == `UNLOCK_KEY);
  wire [1:0] freq_code = osc_reg[`FREQ_LSB+1:`FREQ_LSB];

  // ========================================================================
  // load in first cycle after reset release, then count start-up and pin hold-off
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg    <= ST_LOAD;
      osc_reg      <= `OSC_CFG_RST;
      tfault_reg   <= 8'h00;
      sys0_reg     <= `SYS_PRIMARY_RST;
      sut_reg      <= `STARTUP_RST;
      app_code_end_cfg_reg   <= 8'h00;
      boot_section_end_reg  <= 8'h00;
      lock_reg     <= 8'h00;
      sut_cnt_reg  <= 32'h0;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          osc_reg     <= nv_osc_cfg_i;
          tfault_reg  <= nv_timer_fault_i;
          sys0_reg    <= nv_sys_primary_i;
          sut_reg     <= nv_startup_i;
          app_code_end_cfg_reg  <= nv_app_end_i;
          boot_section_end_reg <= nv_boot_end_i;
          lock_reg    <= nv_lock_key_i;
          state_reg   <= ST_WAIT;
        end
        ST_WAIT: begin
          if (sut_cnt_reg >= sut_target) begin
            state_reg <= ST_RUN;
          end else begin
            sut_cnt_reg <= sut_cnt_reg + 32'h1;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end

  // ========================================================================
  // pin driver hold-off counter
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_cnt_reg <= 24'h0;
    end else if (state_reg != ST_LOAD && hold_cnt_reg < HOLDOFF_CLKS[23:0]) begin
      hold_cnt_reg <= hold_cnt_reg + 24'h1;
    end
  end

  always @* begin
    sut_target = sut_ms(sut_reg[`SUT_LSB+2:`SUT_LSB]) * CLKS_PER_MS;
  end

  // ========================================================================
  // flash section decode
  always @* begin
    if (boot_section_end_reg == 8'h00 || flash_blk_i < boot_section_end_reg) begin
      region_next = REG_BOOT;
    end else if (app_code_end_cfg_reg == 8'h00 || flash_blk_i < app_code_end_cfg_reg) begin
      region_next = REG_CODE;
    end else begin
      region_next = REG_DATA;
    end
  end

  // ========================================================================
  // decoded oscillator outputs
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_run_20m_o     <= 1'b0;
      osc_cfg_valid_o   <= 1'b0;
      osc_coarse_trim_o <= 8'h00;
      osc_temp_trim_o   <= 4'h0;
    end else begin
      osc_run_20m_o     <= freq_is_20m(freq_code);
      osc_cfg_valid_o   <= freq_is_valid(freq_code);
      osc_coarse_trim_o <= freq_is_20m(freq_code) ? osc_coarse_20m_i : osc_coarse_16m_i;
      osc_temp_trim_o   <= freq_is_20m(freq_code) ? osc_temp_20m_i : osc_temp_16m_i;
    end
  end

  // ========================================================================
  // decoded timer outputs
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_fault_control_o <= 8'h00;
      cmp_pin_out_en_o      <= 4'h0;
      cmp_level_o           <= 4'h0;
    end else begin
      timer_fault_control_o <= tfault_reg;
      cmp_pin_out_en_o      <= tfault_reg[7:4];
      if (state_reg == ST_WAIT || (debug_entry_i && fault_detect_flag_i)) begin
        cmp_level_o <= tfault_reg[3:0];
      end
    end
  end

  // ========================================================================
  // decoded system outputs
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scan_source_sel_o       <= `SCAN_NONE;
      shared_reset_pin_func_o <= `RST_FUNC_DEBUG;
      gpio_drv_allow_o        <= 1'b0;
      eeprom_erase_o          <= 1'b0;
      start_exec_o            <= 1'b0;
    end else begin
      scan_source_sel_o       <= sys0_reg[`SCAN_SRC_LSB+1:`SCAN_SRC_LSB];
      shared_reset_pin_func_o <= pin_func_of(sys0_reg);
      gpio_drv_allow_o        <= (pin_func_of(sys0_reg) == `RST_FUNC_GPIO) &&
                                 (hold_cnt_reg >= HOLDOFF_CLKS[23:0]);
      eeprom_erase_o          <= erase_req_reg &&
                                 (!sys0_reg[`EE_KEEP_BIT] || !unlocked);
      start_exec_o            <= (state_reg == ST_RUN);
    end
  end

  // ========================================================================
  // decoded access outputs
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      locked_o       <= 1'b1;
      dbg_grant_o    <= 1'b0;
      flash_region_o <= REG_BOOT;
    end else begin
      locked_o       <= !unlocked;
      dbg_grant_o    <= dbg_req_i && (unlocked || dbg_is_info_blk_i);
      flash_region_o <= region_next;
    end
  end

  // ========================================================================
  // axi4-lite slave
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_idx_reg    <= 4'h0;
      wdata_reg     <= 8'h00;
      erase_req_reg <= 1'b0;
    end else begin
      erase_req_reg <= 1'b0;
      s_axi_awready <= !aw_got_reg && s_axi_awvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_reg && s_axi_wvalid && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_idx_reg == `IDX_ERASE_CTRL) begin
          s_axi_bresp   <= 2'h0;
          erase_req_reg <= wdata_reg[0];
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // axi4-lite read channel
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_next;
        s_axi_rresp  <= 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // read data select
  always @* begin
    case (ar_idx)
      `IDX_OSC_CFG: begin
        rdata_next = {24'h0, osc_reg};
      end
      `IDX_TIMER_FAULT: begin
        rdata_next = {24'h0, tfault_reg};
      end
      `IDX_SYS_PRIMARY: begin
        rdata_next = {24'h0, sys0_reg};
      end
      `IDX_STARTUP: begin
        rdata_next = {24'h0, sut_reg};
      end
      `IDX_APP_END: begin
        rdata_next = {24'h0, app_code_end_cfg_reg};
      end
      `IDX_BOOT_END: begin
        rdata_next = {24'h0, boot_section_end_reg};
      end
      `IDX_LOCK_KEY: begin
        rdata_next = {24'h0, lock_reg};
      end
      `IDX_STATUS: begin
        rdata_next = {28'h0, gpio_drv_allow_o, locked_o, state_reg};
      end
      default: begin
        rdata_next = 32'h0;
      end
    endcase
  end

endmodule // fuse_config_decode

/* File: rtl/fuse_cfg_consts.vh */
// constants for the configuration byte decoder
`ifndef FUSE_CFG_CONSTS_VH
`define FUSE_CFG_CONSTS_VH
// ==========================================================================
// register byte addresses (printed offsets are indices, address is 4x)
`define IDX_OSC_CFG        4'h2
`define IDX_TIMER_FAULT    4'h4
`define IDX_SYS_PRIMARY    4'h5
`define IDX_STARTUP        4'h6
`define IDX_APP_END        4'h7
`define IDX_BOOT_END       4'h8
`define IDX_LOCK_KEY       4'hA
`define IDX_STATUS         4'hC
`define IDX_ERASE_CTRL     4'hD
// ==========================================================================
// field positions
`define FREQ_LSB           0
`define SCAN_SRC_LSB       6
`define RST_FUNC_LSB       2
`define EE_KEEP_BIT        0
`define SUT_LSB            0
// ==========================================================================
// reset values and codes
`define SYS_PRIMARY_RST    8'hC4
`define STARTUP_RST        8'h07
`define OSC_CFG_RST        8'h02
`define FREQ_16M           2'h1
`define FREQ_20M           2'h2
`define SCAN_FULL          2'h0
`define SCAN_BOOT          2'h1
`define SCAN_BOOTAPP       2'h2
`define SCAN_NONE          2'h3
`define RST_FUNC_GPIO      2'h0
`define RST_FUNC_DEBUG     2'h1
`define RST_FUNC_RESET     2'h2
`define UNLOCK_KEY         8'hC5
`define BLOCK_BYTES        256
// ==========================================================================
// timing
`define CLK_HZ             10000000
`define LFOSC_HZ           32768
`define HOLDOFF_LF_CYCLES  768
`define HOLDOFF_CLKS       ((`HOLDOFF_LF_CYCLES * `CLK_HZ + `LFOSC_HZ - 1) / `LFOSC_HZ)
`define CLKS_PER_MS        (`CLK_HZ / 1000)
`endif

/* File: test/fuse_config_decode_props.sv */
// property checker for the configuration byte decoder
`timescale 1ns/1ps
module fuse_config_decode_props #(
  parameter HOLDOFF_CLKS = 20
) (
  input wire       clk_i,
  input wire       arst_n_i,
  input wire       start_exec_o,
  input wire [7:0] timer_fault_control_o,
  input wire       locked_o,
  input wire [3:0] cmp_pin_out_en_o,
  input wire [3:0] cmp_level_o,
  input wire       debug_entry_i,
  input wire       fault_detect_flag_i,
  input wire       dbg_req_i,
  input wire       dbg_is_info_blk_i,
  input wire       dbg_grant_o,
  input wire       gpio_drv_allow_o,
  input wire [1:0] shared_reset_pin_func_o,
  input wire       osc_run_20m_o,
  input wire       osc_cfg_valid_o
);
  reg [19:0] age_reg;
  // ==========================================================================
  // cycles since reset release
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) age_reg <= 20'h00000;
    else if (age_reg != 20'hFFFFF) age_reg <= age_reg + 20'h00001;
  end
  // ==========================================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_hold_stable: assert property (
    start_exec_o && $past(start_exec_o) |->
      $stable({timer_fault_control_o, locked_o, shared_reset_pin_func_o}))
    else $error("decoded values changed at run time");
  chk_pin_enable: assert property (
    start_exec_o |-> cmp_pin_out_en_o == timer_fault_control_o[7:4])
    else $error("pin enables differ from timer byte");
  chk_debug_level: assert property (
    start_exec_o && debug_entry_i && fault_detect_flag_i |=> cmp_level_o == timer_fault_control_o[3:0])
    else $error("debug entry level wrong");
  chk_grant_lock: assert property (
    start_exec_o |=> dbg_grant_o == $past(dbg_req_i && (!locked_o || dbg_is_info_blk_i)))
    else $error("debug grant ignores lock");
  chk_gpio_holdoff: assert property (
    gpio_drv_allow_o |-> age_reg >= HOLDOFF_CLKS)
    else $error("pin driver allowed too early");
  chk_gpio_release: assert property (
    age_reg == HOLDOFF_CLKS + 8 && shared_reset_pin_func_o == 2'h0 |-> gpio_drv_allow_o)
    else $error("pin driver never allowed");
  chk_gpio_func: assert property (
    gpio_drv_allow_o |-> shared_reset_pin_func_o == 2'h0)
    else $error("pin driver allowed outside gpio mode");
  chk_osc_valid: assert property (
    osc_run_20m_o |-> osc_cfg_valid_o)
    else $error("fast oscillator on reserved code");
  cover property (start_exec_o && dbg_req_i && locked_o && dbg_is_info_blk_i);
  cover property ($rose(gpio_drv_allow_o));
  cover property (start_exec_o && debug_entry_i && fault_detect_flag_i);
endmodule // fuse_config_decode_props
bind fuse_config_decode fuse_config_decode_props #(.HOLDOFF_CLKS(HOLDOFF_CLKS)) props_inst (
  .clk_i, .arst_n_i, .start_exec_o, .timer_fault_control_o, .locked_o, .cmp_pin_out_en_o,
  .cmp_level_o, .debug_entry_i, .fault_detect_flag_i, .dbg_req_i, .dbg_is_info_blk_i,
  .dbg_grant_o, .gpio_drv_allow_o, .shared_reset_pin_func_o, .osc_run_20m_o, .osc_cfg_valid_o);

/* File: test/periph_debug_model.sv */
// model of the peripherals and debug interface around the decoder
`timescale 1ns/1ps
module periph_debug_model (
  input  wire       clk_i,
  input  wire       gpio_ok_i,
  output reg        dbg_req_o,
  output reg        info_blk_o,
  output reg        dbg_entry_o,
  output reg        fault_det_o,
  output reg  [7:0] blk_o,
  output reg        pin_irq_en_o
);
  reg [31:0] rnd;
  // ==========================================================================
  // random debug traffic and flash lookups
  initial begin
    {dbg_req_o, info_blk_o, dbg_entry_o, fault_det_o, blk_o, pin_irq_en_o} = 13'h0000;
  end
  always @(posedge clk_i) begin
    rnd = $urandom;
    {dbg_req_o, info_blk_o, dbg_entry_o, fault_det_o} <= rnd[3:0];
    blk_o <= {3'h0, rnd[8:4]};
    pin_irq_en_o <= gpio_ok_i;
  end
endmodule // periph_debug_model

/* File: test/fuse_config_decode_tb_top.sv */
// self-checking bench for the configuration byte decoder
`timescale 1ns/1ps
module fuse_config_decode_tb_top;
  localparam HO = 20;
  localparam MS = 3;
  logic        clk_i = 1'h0, arst_n_i = 1'h0;
  logic [7:0]  nv_osc_cfg_i = 8'h00, nv_timer_fault_i = 8'h00, nv_sys_primary_i = 8'h00;
  logic [7:0]  nv_startup_i = 8'h00, nv_app_end_i = 8'h00, nv_boot_end_i = 8'h00;
  logic [7:0]  nv_lock_key_i = 8'h00, osc_coarse_16m_i = 8'h00, osc_coarse_20m_i = 8'h00;
  logic [3:0]  osc_temp_16m_i = 4'h0, osc_temp_20m_i = 4'h0, s_axi_wstrb = 4'hF;
  logic [1:0]  osc_trim_16m_i = 2'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d, r;
  wire         debug_entry_i, fault_detect_flag_i, dbg_req_i, dbg_is_info_blk_i, pin_irq_en;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp, scan_source_sel_o, shared_reset_pin_func_o;
  wire [1:0]   flash_region_o;
  wire [31:0]  s_axi_rdata;
  wire [7:0]   flash_blk_i, osc_coarse_trim_o, timer_fault_control_o;
  wire [3:0]   osc_temp_trim_o, cmp_pin_out_en_o, cmp_level_o;
  wire         osc_run_20m_o, osc_cfg_valid_o, gpio_drv_allow_o, eeprom_erase_o;
  wire         start_exec_o, locked_o, dbg_grant_o;
  integer      mismatches = 0, compares = 0, t, n;
  logic [55:0] vals;
  logic [7:0]  x;
  logic [1:0]  rsp;
  logic        g, seen;
  // ==========================================================================
  // clock, design and far side
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  fuse_config_decode #(.HOLDOFF_CLKS(HO), .CLKS_PER_MS(MS)) fuse_config_decode_inst (.*);
  periph_debug_model periph_debug_model_inst (
    .clk_i(clk_i), .gpio_ok_i(gpio_drv_allow_o), .dbg_req_o(dbg_req_i),
    .info_blk_o(dbg_is_info_blk_i), .dbg_entry_o(debug_entry_i),
    .fault_det_o(fault_detect_flag_i), .blk_o(flash_blk_i), .pin_irq_en_o(pin_irq_en));
  always @(posedge clk_i) if (eeprom_erase_o === 1'b1) seen = 1'b1;
  // ==========================================================================
  // helpers
  function [1:0] region_of(input [7:0] b, input [7:0] a, input [7:0] p);
    region_of = (b == 8'h00 || p < b) ? 2'h0 : (a == 8'h00 || p < a) ? 2'h1 : 2'h2;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task tmo(input hit);
    begin
      if (hit) begin
        mismatches = mismatches + 1;
        print_verdict;
      end
    end
  endtask
  task axw(input [3:0] i, input [31:0] v, output [1:0] resp);
    integer k;
    begin
      @(posedge clk_i);
      s_axi_awaddr <= {26'h0, i, 2'h0};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k = k + 1) begin
        @(posedge clk_i);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tmo(k == 50);
    end
  endtask
  task axr(input [3:0] i, output [31:0] v);
    integer k;
    begin
      @(posedge clk_i);
      s_axi_araddr <= {26'h0, i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k = k + 1) begin
        @(posedge clk_i);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      v = s_axi_rdata;
      s_axi_rready <= 1'b0;
      tmo(k == 50);
    end
  endtask
  // ==========================================================================
  // one reset and load per test, every frequency and delay code
  initial begin
    r = $urandom(32'hE321);
    for (t = 0; t < 8; t = t + 1) begin
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      r = $urandom;
      nv_osc_cfg_i <= {r[7:2], t[1:0]};
      nv_timer_fault_i <= r[15:8];
      nv_sys_primary_i <= r[23:16];
      nv_startup_i <= {r[31:27], t[2:0]};
      nv_lock_key_i <= t[0] ? 8'hC5 : r[31:24];
      nv_boot_end_i <= (t == 4 || t == 6) ? 8'h00 : {5'h00, r[4:2]} + 8'h01;
      nv_app_end_i <= (t == 4 || t == 5) ? 8'h00 : {5'h00, r[30:28]} + 8'h0A;
      r = $urandom;
      {osc_coarse_16m_i, osc_coarse_20m_i, osc_temp_16m_i, osc_temp_20m_i} <= r[23:0];
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      chk({scan_source_sel_o, shared_reset_pin_func_o, locked_o}, 5'h1B);
      @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (n = 0; n < 300 && start_exec_o !== 1'b1; n = n + 1) begin
        @(negedge clk_i);
        if (n < 3) chk(gpio_drv_allow_o, 0);
      end
      tmo(n == 300);
      d = (t == 0) ? 0 : MS << (t - 1);
      chk(n >= d && n <= d + 4, 1);
      @(negedge clk_i);
      chk(osc_run_20m_o, t[1:0] == 2'h2);
      chk(osc_cfg_valid_o, t[1:0] == 2'h1 || t[1:0] == 2'h2);
      chk(osc_coarse_trim_o, t[1:0] == 2'h2 ? osc_coarse_20m_i : osc_coarse_16m_i);
      chk(osc_temp_trim_o, t[1:0] == 2'h2 ? osc_temp_20m_i : osc_temp_16m_i);
      chk({timer_fault_control_o, cmp_pin_out_en_o, cmp_level_o}, {2{nv_timer_fault_i}});
      chk({scan_source_sel_o, 2'h0, shared_reset_pin_func_o, 2'h0}, nv_sys_primary_i & 8'hCC);
      chk(locked_o, nv_lock_key_i != 8'hC5);
      axw(4'h5, 32'h000000FF, rsp);
      chk(rsp, 2'h2);
      vals = {nv_lock_key_i, nv_boot_end_i, nv_app_end_i, nv_startup_i, nv_sys_primary_i,
              nv_timer_fault_i, nv_osc_cfg_i};
      for (n = 0; n < 7; n = n + 1) begin
        axr(28'hA876542 >> (4 * n), d);
        chk(d, {24'h0, vals[8 * n +: 8]});
      end
      axr(4'h3, d);
      chk(d, 32'h0);
      seen = 1'b0;
      axw(4'hD, 32'h1, rsp);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk({rsp, seen}, {2'h0, !nv_sys_primary_i[0] || nv_lock_key_i != 8'hC5});
      chk(gpio_drv_allow_o, nv_sys_primary_i[3:2] == 2'h0);
      repeat (16) begin
        @(posedge clk_i);
        x = flash_blk_i;
        g = dbg_req_i && (nv_lock_key_i == 8'hC5 || dbg_is_info_blk_i);
        @(negedge clk_i);
        chk(dbg_grant_o, g);
        chk(flash_region_o, region_of(nv_boot_end_i, nv_app_end_i, x));
      end
      @(posedge clk_i);
      nv_timer_fault_i <= ~nv_timer_fault_i;
      nv_lock_key_i <= ~nv_lock_key_i;
      repeat (3) @(negedge clk_i);
      chk({timer_fault_control_o, locked_o}, {~nv_timer_fault_i, ~nv_lock_key_i != 8'hC5});
      $display("test %0d done", t);
    end
    print_verdict;
  end
endmodule // fuse_config_decode_tb_top
